// File: pkg/ecgsw_link_if.sv
// Carrier between the serial link engine and the core register bank.
// Assumes words and their toggles are held stable long before each flip.
interface ecgsw_link_if;
    // Link to core: last received word and its event toggle
    logic [31:0] word;
    logic word_tgl;
    // Core to link: read-back data and its event toggle
    logic [23:0] rsp_data;
    logic rsp_tgl;

    modport link (output word, output word_tgl, input rsp_data, input rsp_tgl);
    modport core (input word, input word_tgl, output rsp_data, output rsp_tgl);
endinterface

// File: pkg/ecgsw_pkg.sv
// Constants for the serial word decoder and acquisition control bank.
// Assumes one core clock at 250 MHz and a separate serial link clock.
package ecgsw_pkg;

    // ------------------------------------------------------------------
    // Serial word layout
    // ------------------------------------------------------------------
    localparam int WORD_W = 32;
    localparam int DATA_W = 24;
    localparam int ADDR_W = 7;
    localparam int RW_POS = 31;
    localparam int ADDR_MSB = 30;
    localparam int ADDR_LSB = 24;
    localparam int HDR_BITS = 8;
    localparam logic [4:0] HDR_LAST_CNT = 5'h07;
    localparam logic [4:0] WORD_LAST_CNT = 5'h1F;
    localparam logic RW_WRITE = 1'b1;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ACQ_CTL_ADDR = 7'h01;
    localparam logic [DATA_W-1:0] ACQ_CTL_RESET = 24'h000000;
    // Defined fields: 23..21 and 10..1; reserved 20..11 and bit 0 read zero
    localparam logic [DATA_W-1:0] ACQ_CTL_MASK = 24'hE007FE;

    // ------------------------------------------------------------------
    // Acquisition control field positions
    // ------------------------------------------------------------------
    localparam int CH_ON_MSB = 23;
    localparam int CH_ON_LSB = 21;
    localparam int INPUT_CFG_POS = 10;
    localparam int GAIN_MSB = 9;
    localparam int GAIN_LSB = 8;
    localparam int REF_BUF_POS = 7;
    localparam int EXT_CLK_POS = 6;
    localparam int MASTER_POS = 5;
    localparam int GANG_POS = 4;

    // ------------------------------------------------------------------
    // Gain codes and gain in tenths
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ECGSW_GAIN_1P4 = 2'h0,
        ECGSW_GAIN_2P1 = 2'h1,
        ECGSW_GAIN_2P8 = 2'h2,
        ECGSW_GAIN_4P2 = 2'h3
    } ecgsw_gain_t;
    localparam logic [5:0] GAIN_X10_1P4 = 6'h0E;
    localparam logic [5:0] GAIN_X10_2P1 = 6'h15;
    localparam logic [5:0] GAIN_X10_2P8 = 6'h1C;
    localparam logic [5:0] GAIN_X10_4P2 = 6'h2A;

endpackage

// File: rtl/ecgsw_serial.sv
// Serial link engine on the link clock: shifts 32-bit words in and out.
// Assumes the link clock runs only while the select pin is low.
module ecgsw_serial (
    // Link clock and frame pins
    input wire logic link_clk,
    input wire logic link_rst,
    input wire logic spi_cs_n,
    input wire logic spi_sdi,
    output logic spi_sdo,
    // Toward the core
    ecgsw_link_if.link lnk
);

    logic [4:0] bit_cnt_reg;
    logic [30:0] rx_reg;
    logic [23:0] tx_reg;
    logic rsp_sync1_reg;
    logic rsp_sync2_reg;
    logic rsp_seen_reg;
    logic word_tgl_reg;
    logic [31:0] word_reg;

    // ------------------------------------------------------------------
    // Bit counter, cleared by the frame's own select pin
    // ------------------------------------------------------------------
    // Clock stops between frames, so only deselect can end the count
    always_ff @(posedge link_clk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            bit_cnt_reg <= 5'h00;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01; // RULE_01
        end
    end

    // Receive shift, most significant bit first
    always_ff @(posedge link_clk) begin
        rx_reg <= {rx_reg[29:0], spi_sdi}; // RULE_01
    end

    // Completed word is held until the next one, 32 link clocks later
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            word_reg <= 32'h00000000;
            word_tgl_reg <= 1'b0;
        end else if (!spi_cs_n && bit_cnt_reg == ecgsw_pkg::WORD_LAST_CNT) begin
            word_reg <= {rx_reg, spi_sdi}; // RULE_01
            word_tgl_reg <= ~word_tgl_reg;
        end
    end

    // ------------------------------------------------------------------
    // Read-back path
    // ------------------------------------------------------------------
    // Toggle synchroniser; header bits give it time before data is needed
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            rsp_sync1_reg <= 1'b0;
            rsp_sync2_reg <= 1'b0;
        end else begin
            rsp_sync1_reg <= lnk.rsp_tgl;
            rsp_sync2_reg <= rsp_sync1_reg;
        end
    end

    // Load only on a fresh toggle, when the core data is known stable
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            tx_reg <= 24'h000000;
            rsp_seen_reg <= 1'b0;
        end else if (bit_cnt_reg == ecgsw_pkg::HDR_LAST_CNT &&
                     rsp_sync2_reg != rsp_seen_reg) begin
            tx_reg <= lnk.rsp_data;
            rsp_seen_reg <= rsp_sync2_reg;
        end
    end

    // Output changes on the falling edge so the host samples on rising
    always_ff @(negedge link_clk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            spi_sdo <= 1'b0;
        end else if (bit_cnt_reg < 5'(ecgsw_pkg::HDR_BITS)) begin
            spi_sdo <= 1'b0;
        end else begin
            spi_sdo <= tx_reg[5'h1F - bit_cnt_reg]; // RULE_01
        end
    end

    assign lnk.word = word_reg;
    assign lnk.word_tgl = word_tgl_reg;

endmodule

// File: rtl/ecgsw_top.sv
// Acquisition control register bank behind a 32-bit serial word link.
// Assumes the host drives select, data and link clock; core_clk is free.

// Summary of operation
// RULE_01: 32-bit word: rw, address, 24 data MSB-first
// RULE_02: Bits 23..21 power each electrode channel
// RULE_03: Bit 10 selects single-ended or differential inputs
// RULE_04: Bits 9..8 select gain 1.4/2.1/2.8/4.2
// RULE_05: Host calibrates gain before using highest code
// RULE_06: Bit 7 enables reference buffer, default off
// RULE_07: Bit 6 selects crystal or external clock pin
// RULE_08: Gang slave stops crystal, clocks from master
// RULE_09: Bit 5 master drives gang sync pin out
// RULE_10: Master bit ignored while gang is disabled
// RULE_11: Gang bit activates clock pin and sync pin
// RULE_12: Control register at 0x01, read/write, resets zero
// RULE_13: Host writes zeros to reserved bits 20..11
// RULE_14: Read returns last written defined field values
module ecgsw_top (
    // Core clock, reset and enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // Serial link
    input wire logic link_clk,
    input wire logic spi_cs_n,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    // Analog front-end controls
    output logic [2:0] channel_on,
    output logic input_config_select,
    output logic [1:0] gain_code,
    output logic [5:0] gain_x10,
    output logic reference_buffer_on,
    // Clock source controls
    output logic crystal_oscillator_on,
    output logic clock_from_pin,
    // Shared clock pin
    input wire logic clk_io_in,
    output logic clk_io_out,
    output logic clk_io_oe,
    // Gang synchronisation pin
    input wire logic sync_gang_in,
    input wire logic sync_req,
    output logic sync_gang_out,
    output logic sync_gang_oe,
    output logic gang_sync_seen
);

    ecgsw_link_if lnk ();

    logic link_rst_s1_reg;
    logic link_rst_s2_reg;
    logic word_s1_reg;
    logic word_s2_reg;
    logic word_seen_reg;
    logic word_event;
    logic [31:0] word_hold;
    logic [ecgsw_pkg::DATA_W-1:0] ctl_reg;
    logic [ecgsw_pkg::DATA_W-1:0] ctl_next;
    logic [ecgsw_pkg::DATA_W-1:0] rsp_data_reg;
    logic rsp_tgl_reg;
    logic clk_in_s1_reg;
    logic clk_in_s2_reg;
    logic sync_in_s1_reg;
    logic sync_in_s2_reg;
    logic gang_on;
    logic master_on;

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    // Used for both the write and the read decode
    function automatic logic ecgsw_is_ctl(input logic [ecgsw_pkg::ADDR_W-1:0] addr);
        ecgsw_is_ctl = (addr == ecgsw_pkg::ACQ_CTL_ADDR);
    endfunction

    // Gain in tenths for the analog gain stage
    function automatic logic [5:0] ecgsw_gain_x10(input logic [1:0] code);
        case (ecgsw_pkg::ecgsw_gain_t'(code))
            ecgsw_pkg::ECGSW_GAIN_1P4: ecgsw_gain_x10 = ecgsw_pkg::GAIN_X10_1P4;
            ecgsw_pkg::ECGSW_GAIN_2P1: ecgsw_gain_x10 = ecgsw_pkg::GAIN_X10_2P1;
            ecgsw_pkg::ECGSW_GAIN_2P8: ecgsw_gain_x10 = ecgsw_pkg::GAIN_X10_2P8;
            ecgsw_pkg::ECGSW_GAIN_4P2: ecgsw_gain_x10 = ecgsw_pkg::GAIN_X10_4P2;
            default: ecgsw_gain_x10 = ecgsw_pkg::GAIN_X10_1P4;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Link engine
    // ------------------------------------------------------------------
    // Reset carried into the link domain; acts only while the link clock runs
    always_ff @(posedge link_clk) begin
        link_rst_s1_reg <= rst;
        link_rst_s2_reg <= link_rst_s1_reg;
    end

    ecgsw_serial u_serial (
        .link_clk(link_clk),
        .link_rst(link_rst_s2_reg),
        .spi_cs_n(spi_cs_n),
        .spi_sdi(spi_sdi),
        .spi_sdo(spi_sdo),
        .lnk(lnk.link)
    );

    // Data out is driven only while selected
    assign spi_sdo_oe = ~spi_cs_n;

    // ------------------------------------------------------------------
    // Word arrival crossing
    // ------------------------------------------------------------------
    // Toggle synchroniser; word itself is stable for 32 link clocks
    always_ff @(posedge core_clk) begin
        if (ce) begin
            word_s1_reg <= lnk.word_tgl;
            word_s2_reg <= word_s1_reg;
        end
    end

    // Reset adopts the current toggle so no stale word is taken
    always_ff @(posedge core_clk) begin
        if (rst) begin
            word_seen_reg <= word_s2_reg;
        end else if (ce) begin
            word_seen_reg <= word_s2_reg;
        end
    end

    assign word_event = ce && !rst && (word_s2_reg != word_seen_reg);
    assign word_hold = lnk.word;

    // ------------------------------------------------------------------
    // Acquisition control register
    // ------------------------------------------------------------------
    // Reserved bits are dropped so read-back never echoes them
    always_comb begin
        ctl_next = ctl_reg;
        if (word_event && word_hold[ecgsw_pkg::RW_POS] == ecgsw_pkg::RW_WRITE &&
            ecgsw_is_ctl(word_hold[ecgsw_pkg::ADDR_MSB:ecgsw_pkg::ADDR_LSB])) begin
            ctl_next = word_hold[ecgsw_pkg::DATA_W-1:0] & ecgsw_pkg::ACQ_CTL_MASK; // RULE_12
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctl_reg <= ecgsw_pkg::ACQ_CTL_RESET; // RULE_12
        end else if (ce) begin
            ctl_reg <= ctl_next;
        end
    end

    // ------------------------------------------------------------------
    // Read-back crossing
    // ------------------------------------------------------------------
    // Data and toggle load here on the same edge; unmapped reads give zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rsp_data_reg <= ecgsw_pkg::ACQ_CTL_RESET;
            rsp_tgl_reg <= 1'b0;
        end else if (word_event && word_hold[ecgsw_pkg::RW_POS] != ecgsw_pkg::RW_WRITE) begin
            if (ecgsw_is_ctl(word_hold[ecgsw_pkg::ADDR_MSB:ecgsw_pkg::ADDR_LSB])) begin
                rsp_data_reg <= ctl_reg & ecgsw_pkg::ACQ_CTL_MASK; // RULE_14
            end else begin
                rsp_data_reg <= 24'h000000;
            end
            rsp_tgl_reg <= ~rsp_tgl_reg;
        end
    end

    assign lnk.rsp_data = rsp_data_reg;
    assign lnk.rsp_tgl = rsp_tgl_reg;

    // ------------------------------------------------------------------
    // Analog front-end controls
    // ------------------------------------------------------------------
    // Cleared channel bit powers it down and floats its input
    always_ff @(posedge core_clk) begin
        if (rst) begin
            channel_on <= 3'h0;
            input_config_select <= 1'b0;
            reference_buffer_on <= 1'b0;
        end else if (ce) begin
            channel_on <= ctl_next[ecgsw_pkg::CH_ON_MSB:ecgsw_pkg::CH_ON_LSB]; // RULE_02
            input_config_select <= ctl_next[ecgsw_pkg::INPUT_CFG_POS]; // RULE_03
            reference_buffer_on <= ctl_next[ecgsw_pkg::REF_BUF_POS]; // RULE_06
        end
    end

    // Highest code needs host calibration; the block only selects it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            gain_code <= 2'h0;
            gain_x10 <= ecgsw_pkg::GAIN_X10_1P4;
        end else if (ce) begin
            gain_code <= ctl_next[ecgsw_pkg::GAIN_MSB:ecgsw_pkg::GAIN_LSB]; // RULE_04
            gain_x10 <= ecgsw_gain_x10(ctl_next[ecgsw_pkg::GAIN_MSB:ecgsw_pkg::GAIN_LSB]); // RULE_04
        end
    end

    // ------------------------------------------------------------------
    // Gang and clock source
    // ------------------------------------------------------------------
    assign gang_on = ctl_reg[ecgsw_pkg::GANG_POS]; // RULE_11
    assign master_on = gang_on & ctl_reg[ecgsw_pkg::MASTER_POS]; // RULE_10

    // Gang slave is forced onto the pin clock and its crystal stops
    always_ff @(posedge core_clk) begin
        if (rst) begin
            crystal_oscillator_on <= 1'b1;
            clock_from_pin <= 1'b0;
        end else if (ce) begin
            crystal_oscillator_on <= ~(gang_on & ~master_on); // RULE_08
            clock_from_pin <= ctl_reg[ecgsw_pkg::EXT_CLK_POS] | (gang_on & ~master_on); // RULE_07
        end
    end

    // Clock pin: master on its crystal drives its level out, slave listens
    always_ff @(posedge core_clk) begin
        if (rst) begin
            clk_io_oe <= 1'b0;
        end else if (ce) begin
            clk_io_oe <= master_on & ~ctl_reg[ecgsw_pkg::EXT_CLK_POS]; // RULE_11
        end
    end

    // Pin level synchronisers
    always_ff @(posedge core_clk) begin
        if (ce) begin
            clk_in_s1_reg <= clk_io_in;
            clk_in_s2_reg <= clk_in_s1_reg;
            sync_in_s1_reg <= sync_gang_in;
            sync_in_s2_reg <= sync_in_s1_reg;
        end
    end

    // Clock pin out mirrors the sampled level for a gang master, else low; a true clock net is outside
    always_ff @(posedge core_clk) begin
        if (rst) begin
            clk_io_out <= 1'b0;
        end else if (ce) begin
            clk_io_out <= master_on & clk_in_s2_reg;
        end
    end

    // Sync pin is an output only for a gang master
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync_gang_oe <= 1'b0;
            sync_gang_out <= 1'b0;
            gang_sync_seen <= 1'b0;
        end else if (ce) begin
            sync_gang_oe <= master_on; // RULE_09
            sync_gang_out <= master_on & sync_req; // RULE_09
            gang_sync_seen <= gang_on & ~master_on & sync_in_s2_reg; // RULE_11
        end
    end

endmodule

// File: verification/ecgsw_host_model.sv
// Serial host model: frames 32-bit words and collects what comes back.
// Assumes callers start it just after a core clock falling edge.
module ecgsw_host_model (
    // Serial pins toward the device
    output logic link_clk,
    output logic spi_cs_n,
    output logic spi_sdi,
    input wire logic spi_sdo,
    // Last complete word shifted back
    output logic [31:0] rx_word,
    output logic rx_tgl
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        link_clk = 1'b0;
        spi_cs_n = 1'b1;
        spi_sdi = 1'b0;
        rx_word = 32'h0;
        rx_tgl = 1'b0;
    end

    // Link clock pulses with no frame, only to let the link reset settle
    task automatic idle_clocks(input int n);
        repeat (n) begin
            #62.5 link_clk = 1'b1;
            #62.5 link_clk = 1'b0;
        end
    endtask

    // Odd 0.3 ns offset keeps link edges clear of core edges
    task automatic xfer(input logic [31:0] w, input int nbits);
        logic [31:0] r;
        r = 32'h0;
        #0.3 spi_cs_n = 1'b0;
        for (int i = 31; i > 31 - nbits; i--) begin
            spi_sdi = w[i];
            #62.5 link_clk = 1'b1;
            r = {r[30:0], spi_sdo};
            #62.5 link_clk = 1'b0;
        end
        #20 spi_cs_n = 1'b1;
        spi_sdi = ~spi_sdi; // Released line must not look held
        if (nbits == 32) begin
            rx_word = r;
            rx_tgl = ~rx_tgl;
        end
    endtask
endmodule

// File: verification/ecgsw_top_sva.sv
// Port-level checker for the acquisition control bank.
// Assumes one core clock domain; ce is only consulted where state may freeze.
module ecgsw_top_sva (
    // Core clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // Serial pins
    input wire logic spi_cs_n,
    input wire logic spi_sdo,
    input wire logic spi_sdo_oe,
    // Front-end and gang controls
    input wire logic [1:0] gain_code,
    input wire logic [5:0] gain_x10,
    input wire logic crystal_oscillator_on,
    input wire logic clock_from_pin,
    input wire logic clk_io_oe,
    input wire logic clk_io_in,
    input wire logic clk_io_out,
    input wire logic sync_gang_in,
    input wire logic sync_req,
    input wire logic sync_gang_out,
    input wire logic sync_gang_oe,
    input wire logic gang_sync_seen
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_sdo_drive_en: assert property (spi_sdo_oe == !spi_cs_n)
        else $error("sdo enable does not follow frame select");
    chk_sdo_idle_low: assert property (spi_cs_n |-> !spi_sdo)
        else $error("sdo not low outside a frame");
    chk_gain_table: assert property (
        gain_x10 == (gain_code == 2'h0 ? 6'h0E : gain_code == 2'h1 ? 6'h15 :
        gain_code == 2'h2 ? 6'h1C : 6'h2A))
        else $error("gain value does not match gain code");
    // Reset itself is the cause here, so it cannot disable the check
    chk_reset_values: assert property (disable iff (1'b0) rst ##1 rst |=>
        gain_code == 2'h0 && crystal_oscillator_on && !clock_from_pin && !sync_gang_oe)
        else $error("outputs not at reset values");
    chk_slave_crystal_oscillator_off: assert property (
        !crystal_oscillator_on |-> clock_from_pin && !sync_gang_oe && !clk_io_oe)
        else $error("crystal off without slave clocking");
    chk_master_keeps: assert property (sync_gang_oe |-> crystal_oscillator_on)
        else $error("master stopped its crystal");
    chk_sync_out_drive: assert property (
        sync_gang_oe && $past(ce) |-> sync_gang_out == $past(sync_req))
        else $error("master sync output does not follow request");
    chk_slave_sync_in: assert property (
        gang_sync_seen |-> !sync_gang_oe && !crystal_oscillator_on)
        else $error("sync input seen outside slave role");
    chk_clk_pin_out: assert property (
        clk_io_oe |-> sync_gang_oe && crystal_oscillator_on && !clock_from_pin)
        else $error("clock pin driven outside master crystal mode");
    // Pin copies lag three edges: two sync stages and the output flop
    chk_clk_out_copy: assert property (
        $past(ce) && $past(ce, 2) && $past(ce, 3) |->
        clk_io_out == (sync_gang_oe && $past(clk_io_in, 3)))
        else $error("clock pin output does not follow sampled input");
    chk_slave_sync_copy: assert property (
        $past(ce) && $past(ce, 2) && $past(ce, 3) |->
        gang_sync_seen == (!crystal_oscillator_on && $past(sync_gang_in, 3)))
        else $error("slave sync flag does not follow sampled pin");

    cov_top_gain: cover property (gain_code == 2'h3);
    cov_clk_master: cover property (clk_io_oe);
    cov_slave_sync: cover property (gang_sync_seen);
endmodule

bind ecgsw_top ecgsw_top_sva chk (.core_clk(core_clk), .rst(rst), .ce(ce),
    .spi_cs_n(spi_cs_n), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .gain_code(gain_code), .gain_x10(gain_x10), .clock_from_pin(clock_from_pin),
    .crystal_oscillator_on(crystal_oscillator_on), .clk_io_oe(clk_io_oe),
    .clk_io_in(clk_io_in), .clk_io_out(clk_io_out), .sync_gang_in(sync_gang_in),
    .sync_req(sync_req), .sync_gang_out(sync_gang_out), .sync_gang_oe(sync_gang_oe),
    .gang_sync_seen(gang_sync_seen));

// File: verification/testbench.sv
// Self-checking bench for the acquisition control bank.
// Assumes the host model is the only serial master; ce drops once only.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------------
    // Signals and bookkeeping
    // ------------------------------------------------------------------
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic clk_io_in = 1'b0;
    logic sync_gang_in = 1'b0;
    logic sync_req = 1'b0;
    logic link_clk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe, rx_tgl;
    logic input_config_select, reference_buffer_on, crystal_oscillator_on, clock_from_pin;
    logic clk_io_out, clk_io_oe, sync_gang_out, sync_gang_oe, gang_sync_seen;
    logic [2:0] channel_on;
    logic [1:0] gain_code;
    logic [5:0] gain_x10;
    logic [31:0] rx_word;
    logic [32:0] q[$];
    logic [32:0] pend = 33'h0;
    logic [32:0] e;
    logic [23:0] shadow = 24'h0;
    logic [23:0] d;
    logic [5:0] gtab [4] = '{6'h0E, 6'h15, 6'h1C, 6'h2A};
    int seed = 9;
    int failures = 0;
    int samples_checked = 0;

    always #2 core_clk = ~core_clk;
    // Random gang pin activity, changed off the sampling edge
    always @(negedge core_clk) {sync_req, clk_io_in, sync_gang_in} <= 3'($random(seed));

    ecgsw_top uut (.core_clk(core_clk), .rst(rst), .ce(ce), .link_clk(link_clk),
        .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
        .channel_on(channel_on), .input_config_select(input_config_select),
        .gain_code(gain_code), .gain_x10(gain_x10), .reference_buffer_on(reference_buffer_on),
        .crystal_oscillator_on(crystal_oscillator_on), .clock_from_pin(clock_from_pin),
        .clk_io_in(clk_io_in), .clk_io_out(clk_io_out), .clk_io_oe(clk_io_oe),
        .sync_gang_in(sync_gang_in), .sync_req(sync_req), .sync_gang_out(sync_gang_out),
        .sync_gang_oe(sync_gang_oe), .gang_sync_seen(gang_sync_seen));

    ecgsw_host_model host (.link_clk(link_clk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
        .spi_sdo(spi_sdo), .rx_word(rx_word), .rx_tgl(rx_tgl));

    // ------------------------------------------------------------------
    // Comparison, verdict and transfer tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (failures == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Expected pin state derived from the last accepted control value
    task automatic check_outputs();
        logic g, m;
        g = shadow[ecgsw_pkg::GANG_POS];
        m = shadow[ecgsw_pkg::MASTER_POS] & g;
        check(32'(channel_on), 32'(shadow[23:21]));
        check(32'(input_config_select), 32'(shadow[10]));
        check(32'({gain_code, gain_x10}), 32'({shadow[9:8], gtab[shadow[9:8]]}));
        check(32'(reference_buffer_on), 32'(shadow[7]));
        check(32'({crystal_oscillator_on, clock_from_pin}),
            32'({~(g & ~m), shadow[6] | (g & ~m)}));
        check(32'({clk_io_oe, sync_gang_oe}), 32'({m & ~shadow[6], m}));
    endtask

    // A read answers in the following word, so the note is queued a frame ahead
    task automatic word(input logic [31:0] w);
        q.push_back(pend);
        host.xfer(w, 32);
        if (w[31] == ecgsw_pkg::RW_WRITE) begin
            pend = 33'h0;
            if (w[30:24] == ecgsw_pkg::ACQ_CTL_ADDR) shadow = w[23:0] & ecgsw_pkg::ACQ_CTL_MASK;
        end else if (w[30:24] == ecgsw_pkg::ACQ_CTL_ADDR) pend = {1'b1, 8'h00, shadow};
        else pend = {1'b1, 32'h0};
        repeat (20) @(negedge core_clk);
        check_outputs();
    endtask

    // Oldest note against each returned word
    always @(rx_tgl) begin
        if (rst === 1'b0) begin
            e = q.pop_front();
            if (e[32]) check(rx_word, e[31:0]);
        end
    end

    // Hang guard
    initial begin
        repeat (60000) @(posedge core_clk);
        failures++;
        final_report();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(negedge core_clk);
        host.idle_clocks(3); // Link side reset needs link edges too
        @(negedge core_clk);
        rst = 1'b0;
        host.idle_clocks(3);
        @(negedge core_clk);
        check_outputs();
        word({1'b0, 7'h01, 24'h0});
        // Every gain code and every gang, role and clock source mix
        for (int i = 0; i < 8; i++) begin
            d = 24'($random(seed));
            d[20:11] = 10'h0;
            d[0] = 1'b0;
            d[6:4] = i[2:0];
            d[9:8] = i[1:0]; // top gain only exercised, no data relied on
            word({1'b1, 7'h01, d});
            word({1'b0, 7'h01, 24'h0});
        end
        word({1'b1, 7'h02, 24'hFFFFFF}); // Other address leaves control alone
        word({1'b0, 7'h02, 24'h0});
        word({1'b0, 7'h01, 24'h0});
        // Cut-short write must be discarded
        q.push_back(pend);
        host.xfer({1'b1, 7'h01, 24'h0}, 16);
        q.pop_back();
        pend = 33'h0;
        repeat (20) @(negedge core_clk);
        check_outputs();
        // Enable low freezes the core; the write lands once it returns
        ce = 1'b0;
        q.push_back(pend);
        host.xfer({1'b1, 7'h01, 24'hE00014}, 32);
        pend = 33'h0;
        repeat (20) @(negedge core_clk);
        check_outputs();
        shadow = 24'hE00014;
        ce = 1'b1;
        repeat (20) @(negedge core_clk);
        check_outputs();
        word({1'b0, 7'h01, 24'h0});
        word({1'b0, 7'h00, 24'h0});
        final_report();
    end
endmodule
